// ### psa_pkg.sv
// Functional notes
// - independent arbiter per secondary segment, up to seven masters each.
// - six external requests plus one internal bridge request, treated alike.
// - every requester sits in a high or low group; both groups considered.
// - group is programmable per master; any mix, even all in one group.
// - round-robin within a group; last granted member becomes lowest.
// - whole low group is one slot in the high-group rotation.
// - 16-bit control register holds group selects and parking choice.
// - with no requests, park on last owner or on the bridge, per control.
// - reset parks on bridge; parked idle bridge drives AD, C/BE#, PAR.
// - six active-low requests and matching active-low grants, index 0 to 5.
`default_nettype none
package psa_pkg;
  localparam int          NUM_EXT       = 6;
  localparam int          NUM_REQ       = 7;
  localparam int          RR_W          = 8;
  localparam logic [2:0]  INT_IDX       = 3'h6;
  localparam logic [2:0]  LOW_SLOT      = 3'h7;
  localparam int          CTRL_W        = 16;
  localparam int          CTRL_GRP_LSB  = 0;
  localparam int          CTRL_PARK_BIT = 7;
  localparam logic [15:0] CTRL_RST      = 16'h0000;
  localparam logic [15:0] CTRL_MASK     = 16'h00ff;
  localparam logic [31:0] PARK_AD       = 32'h0000_0000;
  localparam logic [3:0]  PARK_CBE      = 4'h0;
  localparam logic        PARK_PAR      = 1'b0;
endpackage
`default_nettype wire

// ### psa_rr_if.sv
`timescale 1ns/1ps
`default_nettype none
interface psa_rr_if;
  logic [7:0] req;
  logic [2:0] last;
  logic       found;
  logic [2:0] pick;
  modport requester (output req, output last, input found, input pick);
  modport picker    (input req, input last, output found, output pick);
endinterface
`default_nettype wire

// ### psa_rr_pick.sv
`timescale 1ns/1ps
`default_nettype none
module psa_rr_pick (
  psa_rr_if.picker rr
);
  ////////////////////////////////////////////////////////////////////////////
  // first requester after the last winner
  function automatic logic [3:0] rr_next(input logic [7:0] req,
                                          input logic [2:0] last);
    logic [3:0] res;
    logic [2:0] idx;
    res = 4'h0;
    for (int i = 8; i >= 1; i--) begin
      idx = last + 3'(i);
      if (req[idx]) begin
        res = {1'b1, idx};
      end
    end
    return res;
  endfunction

  wire [3:0] pick_res = rr_next(rr.req, rr.last);
  assign rr.found = pick_res[3];
  assign rr.pick  = pick_res[2:0];
endmodule
`default_nettype wire

// ### psa_segment_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
module psa_segment_arbiter (
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset,
  input  wire logic [5:0]  i_req_n,
  input  wire logic        i_int_req,
  input  wire logic        i_frame_n,
  input  wire logic        i_irdy_n,
  input  wire logic        i_ctrl_wr,
  input  wire logic [15:0] i_ctrl_wdata,
  output logic      [15:0] o_ctrl_rdata,
  output logic      [5:0]  o_gnt_n,
  output logic             o_int_gnt,
  output logic             o_park_oe,
  output logic      [31:0] o_park_ad,
  output logic      [3:0]  o_park_cbe,
  output logic             o_park_par
);
  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [15:0] ctrl_ff;
  logic [6:0]  gnt_ff;
  logic [5:0]  gnt_n_ff;
  logic [2:0]  hi_last_ff;
  logic [2:0]  lo_last_ff;
  logic [2:0]  owner_ff;
  logic        park_oe_ff;
  logic [31:0] park_ad_ff;
  logic [3:0]  park_cbe_ff;
  logic        park_par_ff;

  ////////////////////////////////////////////////////////////////////////////
  // request decode
  wire [6:0] req_all  = {i_int_req, ~i_req_n};
  wire [6:0] grp_high = ctrl_ff[psa_pkg::CTRL_GRP_LSB +: 7];
  wire       park_last = ctrl_ff[psa_pkg::CTRL_PARK_BIT];
  wire [6:0] req_hi   = req_all & grp_high;
  wire [6:0] req_lo   = req_all & ~grp_high;
  wire       any_req  = |req_all;
  wire       bus_idle = i_frame_n & i_irdy_n;

  psa_rr_if hi_if ();
  psa_rr_if lo_if ();

  assign hi_if.req  = {|req_lo, req_hi};
  assign hi_if.last = hi_last_ff;
  assign lo_if.req  = {1'b0, req_lo};
  assign lo_if.last = lo_last_ff;

  psa_rr_pick u_hi_pick (
    .rr (hi_if.picker)
  );

  psa_rr_pick u_lo_pick (
    .rr (lo_if.picker)
  );

  ////////////////////////////////////////////////////////////////////////////
  // winner selection and parking
  wire       hi_is_low = (hi_if.pick == psa_pkg::LOW_SLOT);
  wire [2:0] win_req   = hi_is_low ? lo_if.pick : hi_if.pick;
  wire [2:0] park_idx  = park_last ? owner_ff : psa_pkg::INT_IDX;
  wire [2:0] winner    = any_req ? win_req : park_idx;
  wire [6:0] win_vec   = 7'(7'h01 << winner);
  wire       gnt_any   = |gnt_ff;
  wire       win_held  = |(gnt_ff & win_vec);
  // owner keeps grant while its transaction runs
  wire       busy_own  = !bus_idle && gnt_any;
  wire       do_drop   = gnt_any && !win_held && !busy_own;
  wire       do_grant  = !gnt_any && bus_idle;
  wire [6:0] nxt_gnt   = do_drop  ? 7'h00 :
                         do_grant ? win_vec : gnt_ff;
  wire       new_req_gnt = do_grant && any_req;
  wire       win_high  = |(win_vec & grp_high);
  wire [2:0] nxt_hi_last = (new_req_gnt && win_high)  ? winner :
                           (new_req_gnt && !win_high) ? psa_pkg::LOW_SLOT :
                           hi_last_ff;
  wire [2:0] nxt_lo_last = (new_req_gnt && !win_high) ? winner
                                                       : lo_last_ff;
  wire [2:0] nxt_owner = new_req_gnt ? winner : owner_ff;
  wire       nxt_park_oe = gnt_ff[psa_pkg::INT_IDX] && bus_idle &&
                           !i_int_req;
  wire [15:0] nxt_ctrl = i_ctrl_wr ? (i_ctrl_wdata & psa_pkg::CTRL_MASK)
                                   : ctrl_ff;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      ctrl_ff    <= psa_pkg::CTRL_RST;
      gnt_ff     <= 7'h00;
      gnt_n_ff   <= 6'h3f;
      hi_last_ff <= psa_pkg::LOW_SLOT;
      lo_last_ff <= psa_pkg::INT_IDX;
      owner_ff   <= psa_pkg::INT_IDX;
      park_oe_ff <= 1'b0;
      park_ad_ff  <= psa_pkg::PARK_AD;
      park_cbe_ff <= psa_pkg::PARK_CBE;
      park_par_ff <= psa_pkg::PARK_PAR;
    end else begin
      ctrl_ff    <= nxt_ctrl;
      gnt_ff     <= nxt_gnt;
      gnt_n_ff   <= ~nxt_gnt[5:0];
      hi_last_ff <= nxt_hi_last;
      lo_last_ff <= nxt_lo_last;
      owner_ff   <= nxt_owner;
      park_oe_ff <= nxt_park_oe;
      park_ad_ff  <= psa_pkg::PARK_AD;
      park_cbe_ff <= psa_pkg::PARK_CBE;
      park_par_ff <= psa_pkg::PARK_PAR;
    end
  end

  assign o_ctrl_rdata = ctrl_ff;
  assign o_gnt_n      = gnt_n_ff;
  assign o_int_gnt    = gnt_ff[psa_pkg::INT_IDX];
  assign o_park_oe    = park_oe_ff;
  assign o_park_ad    = park_ad_ff;
  assign o_park_cbe   = park_cbe_ff;
  assign o_park_par   = park_par_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [2:0] idle_cnt_ff;
  always_ff @(posedge i_ref_clk) begin
    if (i_reset || any_req || !bus_idle || park_last) begin
      idle_cnt_ff <= 3'h0;
    end else if (idle_cnt_ff != 3'h7) begin
      idle_cnt_ff <= idle_cnt_ff + 3'h1;
    end
  end

  property p_one_grant;
    @(posedge i_ref_clk) disable iff (i_reset)
      $onehot0(gnt_ff) && $onehot0({gnt_ff[6], ~gnt_n_ff});
  endproperty
  a_one_grant: assert property (p_one_grant)
    else $error("more than one grant asserted");

  property p_grant_gap;
    @(posedge i_ref_clk) disable iff (i_reset)
      (gnt_ff != 7'h00) ##1 (gnt_ff != $past(gnt_ff)) |-> (gnt_ff == 7'h00);
  endproperty
  a_grant_gap: assert property (p_grant_gap)
    else $error("grant moved without an empty cycle");

  property p_busy_hold;
    @(posedge i_ref_clk) disable iff (i_reset)
      gnt_ff != 7'h00 && !bus_idle |=> gnt_ff == $past(gnt_ff);
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("grant moved while bus busy");

  property p_no_grant_busy;
    @(posedge i_ref_clk) disable iff (i_reset)
      gnt_ff == 7'h00 && !bus_idle |=> gnt_ff == 7'h00;
  endproperty
  a_no_grant_busy: assert property (p_no_grant_busy)
    else $error("grant issued while bus busy");

  property p_pins_match;
    @(posedge i_ref_clk) disable iff (i_reset)
      o_gnt_n == ~gnt_ff[5:0];
  endproperty
  a_pins_match: assert property (p_pins_match)
    else $error("grant pins disagree with grant state");

  property p_park_bridge;
    @(posedge i_ref_clk) disable iff (i_reset)
      (idle_cnt_ff == 3'h7) |-> ##[0:2] o_int_gnt;
  endproperty
  a_park_bridge: assert property (p_park_bridge)
    else $error("idle bus not parked on bridge");

  property p_park_drive;
    @(posedge i_ref_clk) disable iff (i_reset)
      o_park_oe |-> $past(gnt_ff[6]) && $past(bus_idle) && !$past(i_int_req);
  endproperty
  a_park_drive: assert property (p_park_drive)
    else $error("bus driven while not parked");

  property p_park_const;
    @(posedge i_ref_clk) disable iff (i_reset)
      o_park_ad == psa_pkg::PARK_AD && o_park_cbe == psa_pkg::PARK_CBE &&
      o_park_par == psa_pkg::PARK_PAR;
  endproperty
  a_park_const: assert property (p_park_const)
    else $error("park values not defined");

  property p_ctrl_write;
    @(posedge i_ref_clk) disable iff (i_reset)
      i_ctrl_wr |=>
        o_ctrl_rdata == ($past(i_ctrl_wdata) & psa_pkg::CTRL_MASK);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("control register did not take write");

  property p_hi_found;
    @(posedge i_ref_clk) disable iff (i_reset)
      hi_if.found == any_req;
  endproperty
  a_hi_found: assert property (p_hi_found)
    else $error("high picker disagrees with requests");

  property p_lo_found;
    @(posedge i_ref_clk) disable iff (i_reset)
      hi_is_low |-> lo_if.found && lo_if.pick != psa_pkg::LOW_SLOT;
  endproperty
  a_lo_found: assert property (p_lo_found)
    else $error("low slot chosen without low requester");

  property p_hi_rotate;
    @(posedge i_ref_clk) disable iff (i_reset)
      new_req_gnt && win_high |=> hi_last_ff == $past(winner);
  endproperty
  a_hi_rotate: assert property (p_hi_rotate)
    else $error("high rotation not advanced");

  property p_low_slot;
    @(posedge i_ref_clk) disable iff (i_reset)
      new_req_gnt && !win_high |=>
        hi_last_ff == 3'h7 && lo_last_ff == $past(winner);
  endproperty
  a_low_slot: assert property (p_low_slot)
    else $error("low group slot not advanced");

  property p_group_pick;
    @(posedge i_ref_clk) disable iff (i_reset)
      new_req_gnt |-> |(win_vec & req_all);
  endproperty
  a_group_pick: assert property (p_group_pick)
    else $error("grant to a non-requester");
endmodule
`default_nettype wire

// ### psa_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module psa_master_model (
  input  wire logic       i_ref_clk,
  input  wire logic       i_reset,
  input  wire logic [5:0] i_gnt_n,
  input  wire logic [5:0] i_want,
  output logic      [5:0] o_req_n,
  output logic            o_frame_n,
  output logic            o_irdy_n
);
  logic [5:0] pend_ff;
  logic [1:0] busy_ff;
  wire  [5:0] start = (busy_ff == 2'h0) ? (pend_ff & ~i_gnt_n)
                                        : 6'h00;
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      pend_ff <= 6'h00;
      busy_ff <= 2'h0;
    end else begin
      pend_ff <= (pend_ff | i_want) & ~start;
      busy_ff <= (start != 6'h00) ? 2'h2 : busy_ff - {1'b0, busy_ff != 2'h0};
    end
  end
  assign o_req_n   = ~pend_ff;
  assign o_frame_n = (busy_ff != 2'h2);
  assign o_irdy_n  = (busy_ff == 2'h0);
endmodule
`default_nettype wire

// ### testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk = 0, rst = 1, wr = 0, ireq = 0, f_prev = 1;
  logic [15:0] wd = 16'h0000;
  logic [5:0]  want = 6'h00, g_prev = 6'h3f;
  wire  [5:0]  req_n, gnt_n;
  wire         frame_n, irdy_n, igt, oe, par;
  wire  [15:0] rdata;
  wire  [31:0] ad;
  wire  [3:0]  cbe;
  int          fail_count = 0, check_count = 0, k;
  logic [2:0]  seq[$];
  logic [7:0]  cfg[3] = '{8'h7f, 8'h03, 8'h83};
  always #2.5 clk = ~clk;
  psa_segment_arbiter psa_segment_arbiter_i (.i_ref_clk(clk), .i_reset(rst),
    .i_req_n(req_n), .i_int_req(ireq), .i_frame_n(frame_n),
    .i_irdy_n(irdy_n), .i_ctrl_wr(wr), .i_ctrl_wdata(wd),
    .o_ctrl_rdata(rdata), .o_gnt_n(gnt_n), .o_int_gnt(igt), .o_park_oe(oe),
    .o_park_ad(ad), .o_park_cbe(cbe), .o_park_par(par));
  psa_master_model psa_master_model_i (.i_ref_clk(clk), .i_reset(rst),
    .i_gnt_n(gnt_n), .i_want(want), .o_req_n(req_n), .o_frame_n(frame_n),
    .o_irdy_n(irdy_n));
  ////////////////////////////////////////////////////////////////////////////
  task chk(string n, logic [31:0] e, logic [31:0] s);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task test_done;
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task wr_ctrl(logic [15:0] v);
    wd = v;
    wr = 1;
    @(negedge clk);
    wr = 0;
    chk("ctrl_rdata", {16'h0, v & psa_pkg::CTRL_MASK}, {16'h0, rdata});
    @(negedge clk);
  endtask
  function logic [2:0] idx(logic [5:0] g);
    for (int i = 0; i < 6; i++) if (!g[i]) return i[2:0];
    return 3'h7;
  endfunction
  function logic [2:0] exp_g(logic [7:0] c, int n);
    if (c[2]) return 3'(n % 6);
    return (n % 3 < 2) ? 3'(n % 3) : 3'(2 + n / 3);
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  always @(negedge clk) begin
    if (!rst) begin
      chk("one_grant", 1, 32'($countones({~gnt_n, igt}) <= 1));
      if (!frame_n && f_prev) seq.push_back(idx(g_prev));
      if (igt && ireq) ireq <= 0;
    end
    f_prev = frame_n;
    g_prev = gnt_n;
  end
  initial begin
    #100000;
    fail_count++;
    test_done;
  end
  initial begin
    void'($urandom(59));
    repeat (6) @(negedge clk);
    chk("rst_state", 24'hfc0000, {gnt_n, igt, oe, rdata});
    rst = 0;
    @(negedge clk);
    chk("park_gnt", 2'h2, {igt, oe});
    @(negedge clk);
    chk("park_oe", 2'h3, {igt, oe});
    repeat (8) wr_ctrl(16'($urandom));
    foreach (cfg[c]) begin
      rst = 1;
      repeat (2) @(negedge clk);
      rst = 0;
      wr_ctrl({8'h00, cfg[c]});
      seq.delete();
      want = 6'h3f;
      for (k = 0; k < 300 && seq.size() < 9; k++) @(negedge clk);
      want = 6'h00;
      for (k = 0; k < 9; k++)
        chk("grant_order", exp_g(cfg[c], k), seq[k]);
      repeat (30) @(negedge clk);
      if (cfg[c][7])
        chk("park_last", 6'(~(6'h01 << seq[$])), gnt_n);
      else
        chk("park_bridge", 8'hff, {gnt_n, igt, oe});
    end
    for (k = 0; k < 400; k++) begin
      want = 6'($urandom) & 6'($urandom);
      if (!igt && !ireq) ireq = ($urandom % 8 == 0);
      if (k % 50 == 0) wr_ctrl(16'($urandom));
      else @(negedge clk);
    end
    want = 6'h00;
    chk("park_ad", psa_pkg::PARK_AD, ad);
    chk("park_cbe", {psa_pkg::PARK_CBE, psa_pkg::PARK_PAR}, {cbe, par});
    test_done;
  end
endmodule
`default_nettype wire
